// ---- design/gpio_bank_pkg.sv ----
// Constants, types and register map of the parallel I/O port bank
// Overview of operation
// R1: Sample every pin once per state time
// R2: Input pin: write latch, read sampled pin
// R3: Input pin modify source is sampled pin
// R4: Direction one enables driver, write reaches pin
// R5: Output pin read returns output latch
// R6: Output pin modify source is output latch
// R7: Six ports have per-bit open-drain select
// R8: Threshold select per byte, two for wide; the code gives port 6 none and ties its cmos_sel to zero
// R9: Direction independent of chosen input threshold
// R10: Third port lacks bit fourteen
// R11: Fifth port is input only, no drivers
// R12: First two ports addressed as byte halves
// R13: Each line has one alternate function
// R14: Alternate output ignored while direction is input
// R15: Alternate output ANDed with latch, except PWM
// R16: Reset selects input direction everywhere
// R17: Output pin feeds latch to alternate input
// R18: Reset-time signals get direction automatically
// R19: External bus switches direction automatically
// R20: Software sets direction before enabling alternates
// R21: Fourth port drives segment address outputs
// R22: Latches and open-drain reset zero
package gpio_bank_pkg;
	typedef logic [8:0][15:0] port_vec_t;
	typedef logic [8:0][1:0]  thr_vec_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic             en;
		logic             drive;
		logic [1:0][15:0] data;
	} ext_bus_t;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
	} seg_addr_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] port;
		logic [15:0] lane;
		logic       hi;
	} view_t;

	typedef struct packed {
		port_vec_t  pin_meta;
		port_vec_t  pin_sync;
		port_vec_t  in_latch;
		port_vec_t  latch;
		port_vec_t  dir;
		port_vec_t  od;
		logic [15:0] thr;
		logic [15:0] xthr;
		logic [15:0] rdata;
		logic [1:0] tick_cnt;
	} gpio_state_t;

	localparam logic [3:0]  KIND_DATA   = 4'h0;
	localparam logic [3:0]  KIND_DIR    = 4'h1;
	localparam logic [3:0]  KIND_OD     = 4'h2;
	localparam logic [3:0]  KIND_TOGGLE = 4'h3;
	localparam logic [7:0]  ADDR_THR    = 8'h40;
	localparam logic [7:0]  ADDR_XTHR   = 8'h41;
	localparam logic [15:0] THR_MASK    = 16'h01FF;
	localparam logic [15:0] XTHR_MASK   = 16'h000F;
	localparam logic [15:0] RESET_WORD  = 16'h0000;
	localparam logic [3:0]  VIEW_LAST   = 4'hA;
	localparam logic [3:0]  VIEW_FULL0  = 4'h4;
	localparam logic [3:0]  PORT_SEG    = 4'h4;
	localparam logic [3:0]  PORT_CHECK  = 4'h2;

	localparam int CLK_PERIOD_NS     = 8;
	localparam int STATE_TIME_NS     = 16;
	localparam int STATE_TIME_CYCLES = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] STATE_LAST = 2'(STATE_TIME_CYCLES - 1);

	localparam port_vec_t IMPL_MASK = {16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF,
		16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	localparam port_vec_t OUT_MASK = {16'h00FF, 16'h00FF, 16'h00FF, 16'h0000, 16'h00FF,
		16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	localparam port_vec_t OD_MASK = {16'h00FF, 16'h00FF, 16'h00FF, 16'h0000, 16'h00FF,
		16'hBFFF, 16'hFFFF, 16'h0000, 16'h0000};

	function automatic view_t decode_view(input logic [3:0] idx);
		view_t v;
		v.valid = (idx <= VIEW_LAST);
		v.hi = 1'b0;
		v.lane = 16'hFFFF;
		v.port = 4'h0;
		if (idx < VIEW_FULL0) begin
			v.port = {3'h0, idx[1]};
			v.hi = idx[0];
			v.lane = idx[0] ? 16'hFF00 : 16'h00FF;
		end else if (v.valid) begin
			v.port = 4'(idx - 4'h2);
		end
		return v;
	endfunction
endpackage

// ---- design/gpio_bank.sv ----
// Parallel I/O port bank: latches, direction, open drain, thresholds, alternates
`timescale 1ns/1ps
module gpio_bank #(
	parameter gpio_bank_pkg::port_vec_t AUTO_MASK = {16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000}
) (
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire gpio_bank_pkg::reg_req_t   req,
	output logic [15:0]                    rdata,
	input  wire gpio_bank_pkg::port_vec_t  pins_i,
	output gpio_bank_pkg::port_vec_t       pins_o,
	output gpio_bank_pkg::port_vec_t       pins_oe,
	input  wire gpio_bank_pkg::port_vec_t  alt_out_en,
	input  wire gpio_bank_pkg::port_vec_t  alt_out_data,
	input  wire gpio_bank_pkg::port_vec_t  alt_pwm_sel,
	output gpio_bank_pkg::port_vec_t       alt_in,
	input  wire gpio_bank_pkg::ext_bus_t   ext_bus,
	input  wire gpio_bank_pkg::seg_addr_t  seg_addr,
	output gpio_bank_pkg::thr_vec_t        cmos_sel
);
	logic [1:0]                rst_pipe;
	logic                      rst_n;
	gpio_bank_pkg::gpio_state_t st;
	gpio_bank_pkg::gpio_state_t next_st;
	gpio_bank_pkg::view_t      view;
	logic [3:0]                kind;
	logic                      tick;
	logic [15:0]               cur;
	logic [15:0]               wv;
	logic [15:0]               sw;

	// Output pins read back their latch, input pins their sampled level
	function automatic logic [15:0] sw_view(input logic [15:0] d, input logic [15:0] l,
		input logic [15:0] i);
		return (d & l) | (~d & i);
	endfunction

	// Puts a byte into the half that the view selects
	function automatic logic [15:0] place(input logic [15:0] x, input logic hi);
		return hi ? {x[7:0], 8'h00} : x;
	endfunction

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	assign tick = (st.tick_cnt == gpio_bank_pkg::STATE_LAST);
	assign kind = req.addr[7:4];
	assign view = gpio_bank_pkg::decode_view(req.addr[3:0]);

	always_comb begin
		next_st = st;
		cur = 16'h0000;
		sw = 16'h0000;
		next_st.pin_meta = pins_i;
		next_st.pin_sync = st.pin_meta;
		next_st.tick_cnt = tick ? 2'h0 : st.tick_cnt + 2'h1;
		if (tick) begin
			next_st.in_latch = st.pin_sync & gpio_bank_pkg::IMPL_MASK; // R1
		end
		next_st.rdata = 16'h0000;
		wv = place(req.wdata, view.hi) & view.lane; // R12
		if (view.valid) begin
			sw = sw_view(st.dir[view.port], st.latch[view.port], st.in_latch[view.port]);
			if (kind == gpio_bank_pkg::KIND_DIR) begin
				cur = st.dir[view.port];
			end else if (kind == gpio_bank_pkg::KIND_OD) begin
				cur = st.od[view.port];
			end else begin
				cur = sw; // R2 R5
			end
		end
		if (req.rd) begin
			if (req.addr == gpio_bank_pkg::ADDR_THR) begin
				next_st.rdata = st.thr;
			end else if (req.addr == gpio_bank_pkg::ADDR_XTHR) begin
				next_st.rdata = st.xthr;
			end else if (view.valid && kind <= gpio_bank_pkg::KIND_TOGGLE) begin
				next_st.rdata = view.hi ? {8'h00, cur[15:8]} : (cur & view.lane);
			end
		end
		if (req.wr) begin
			if (req.addr == gpio_bank_pkg::ADDR_THR) begin
				next_st.thr = req.wdata & gpio_bank_pkg::THR_MASK; // R8
			end else if (req.addr == gpio_bank_pkg::ADDR_XTHR) begin
				next_st.xthr = req.wdata & gpio_bank_pkg::XTHR_MASK; // R8
			end else if (view.valid && kind == gpio_bank_pkg::KIND_DATA) begin
				next_st.latch[view.port] = ((st.latch[view.port] & ~view.lane) | wv)
					& gpio_bank_pkg::OUT_MASK[view.port]; // R2 R4 R10
			end else if (view.valid && kind == gpio_bank_pkg::KIND_TOGGLE) begin
				next_st.latch[view.port] = ((st.latch[view.port] & ~view.lane) | ((sw ^ wv) & view.lane))
					& gpio_bank_pkg::OUT_MASK[view.port]; // R3 R6
			end else if (view.valid && kind == gpio_bank_pkg::KIND_DIR) begin
				next_st.dir[view.port] = ((st.dir[view.port] & ~view.lane) | wv)
					& gpio_bank_pkg::OUT_MASK[view.port]; // R9 R11
			end else if (view.valid && kind == gpio_bank_pkg::KIND_OD) begin
				next_st.od[view.port] = ((st.od[view.port] & ~view.lane) | wv)
					& gpio_bank_pkg::OD_MASK[view.port]; // R7
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0; // R16 R22
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;

	// Pin drivers; automatic pins get their driver enabled by alt_out_en but their value still passes the latch AND
	always_comb begin
		for (int p = 0; p < 9; p++) begin
			logic [15:0] drv_dir;
			logic [15:0] val;
			drv_dir = st.dir[p] | (AUTO_MASK[p] & alt_out_en[p]); // R18
			val = (alt_out_en[p] & ~alt_pwm_sel[p] & alt_out_data[p] & st.latch[p]) // R15
				| (alt_out_en[p] & alt_pwm_sel[p] & alt_out_data[p])
				| (~alt_out_en[p] & st.latch[p]); // R13
			if (ext_bus.en && p < 2) begin
				drv_dir = {16{ext_bus.drive}}; // R19
				val = ext_bus.data[p[0]];
			end
			if (seg_addr.en && p == 4) begin
				drv_dir = 16'h00FF; // R21
				val = {8'h00, seg_addr.addr};
			end
			val = val & gpio_bank_pkg::OUT_MASK[p];
			pins_o[p] = val;
			// Open drain only pulls low; a one leaves the wire to the pull-up
			pins_oe[p] = drv_dir & gpio_bank_pkg::OUT_MASK[p] & ~(st.od[p] & val); // R4 R7 R14
			alt_in[p] = sw_view(st.dir[p], st.latch[p], st.in_latch[p]); // R17
		end
	end

	assign cmos_sel[0] = {st.xthr[1], st.xthr[0]};
	assign cmos_sel[1] = {st.xthr[3], st.xthr[2]};
	assign cmos_sel[2] = st.thr[1:0];
	assign cmos_sel[3] = st.thr[3:2];
	assign cmos_sel[4] = {2{st.thr[4]}};
	assign cmos_sel[5] = st.thr[8:7];
	assign cmos_sel[6] = 2'h0;
	assign cmos_sel[7] = {2{st.thr[5]}};
	assign cmos_sel[8] = {2{st.thr[6]}};

	sequence s_toggle_p2;
		req.wr && req.addr == {gpio_bank_pkg::KIND_TOGGLE, 4'h4};
	endsequence

	sequence s_write_p2;
		req.wr && req.addr == {gpio_bank_pkg::KIND_DATA, 4'h4};
	endsequence

	property p_sample;
		@(posedge sys_clk) disable iff (!rst_n)
		$changed(st.in_latch) |-> $past(tick);
	endproperty
	a_sample: assert property (p_sample) else $error("input latch changed off the state tick"); // R1

	property p_dir_reset;
		@(posedge sys_clk) disable iff (!rst_n)
		$changed(st.dir) |-> $past(req.wr && kind == gpio_bank_pkg::KIND_DIR);
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction moved without a write"); // R16

	property p_read_view;
		@(posedge sys_clk) disable iff (!rst_n)
		req.rd && req.addr == {gpio_bank_pkg::KIND_DATA, 4'h4}
			|=> rdata == $past(sw_view(st.dir[2], st.latch[2], st.in_latch[2]));
	endproperty
	a_read_view: assert property (p_read_view) else $error("port read returned wrong source"); // R5

	property p_write_pin;
		@(posedge sys_clk) disable iff (!rst_n)
		s_write_p2 ##0 (st.dir[2] == 16'hFFFF && alt_out_en[2] == 16'h0000 && st.od[2] == 16'h0000)
			|=> st.latch[2] == $past(req.wdata) && pins_o[2] == $past(req.wdata);
	endproperty
	a_write_pin: assert property (p_write_pin) else $error("written value missing on output pin"); // R4

	property p_toggle;
		@(posedge sys_clk) disable iff (!rst_n)
		s_toggle_p2 |=> st.latch[2] == $past(sw_view(st.dir[2], st.latch[2], st.in_latch[2]) ^ req.wdata);
	endproperty
	a_toggle: assert property (p_toggle) else $error("modify used the wrong source"); // R3

	property p_alt_hiz;
		@(posedge sys_clk) disable iff (!rst_n)
		(pins_oe[7] & ~st.dir[7] & ~AUTO_MASK[7]) == 16'h0000;
	endproperty
	a_alt_hiz: assert property (p_alt_hiz) else $error("input pin driven by alternate output"); // R14

	property p_alt_and;
		@(posedge sys_clk) disable iff (!rst_n)
		(pins_o[7] & alt_out_en[7] & ~alt_pwm_sel[7]) == (alt_out_data[7] & st.latch[7] & alt_out_en[7]
			& ~alt_pwm_sel[7]);
	endproperty
	a_alt_and: assert property (p_alt_and) else $error("alternate output not gated by latch"); // R15

	property p_input_only;
		@(posedge sys_clk) disable iff (!rst_n)
		pins_oe[5] == 16'h0000 && st.latch[3][14] == 1'b0;
	endproperty
	a_input_only: assert property (p_input_only) else $error("missing line or input port driven"); // R11

	property p_alt_in;
		@(posedge sys_clk) disable iff (!rst_n)
		alt_in[2] == ((st.dir[2] & st.latch[2]) | (~st.dir[2] & st.in_latch[2]));
	endproperty
	a_alt_in: assert property (p_alt_in) else $error("alternate input source wrong"); // R17

	property p_seg;
		@(posedge sys_clk) disable iff (!rst_n)
		seg_addr.en |-> pins_oe[4][7:0] == (8'hFF & ~(st.od[4][7:0] & seg_addr.addr))
			&& pins_o[4][7:0] == seg_addr.addr;
	endproperty
	a_seg: assert property (p_seg) else $error("segment address not driven"); // R21

	property p_bus_dir;
		@(posedge sys_clk) disable iff (!rst_n)
		ext_bus.en |-> pins_oe[0] == {16{ext_bus.drive}} && pins_oe[1] == {16{ext_bus.drive}};
	endproperty
	a_bus_dir: assert property (p_bus_dir) else $error("bus direction not switched"); // R19

	property p_in_sample;
		@(posedge sys_clk) disable iff (!rst_n)
		tick |=> st.in_latch == $past(st.pin_sync & gpio_bank_pkg::IMPL_MASK);
	endproperty
	a_in_sample: assert property (p_in_sample) else $error("input latch missed the pin sample"); // R1

	property p_in_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		!tick |=> $stable(st.in_latch);
	endproperty
	a_in_hold: assert property (p_in_hold) else $error("input latch moved between ticks"); // R1

	property p_tick;
		@(posedge sys_clk) disable iff (!rst_n)
		tick |=> st.tick_cnt == 2'h0;
	endproperty
	a_tick: assert property (p_tick) else $error("state time counter did not wrap"); // R1

	property p_read_in;
		@(posedge sys_clk) disable iff (!rst_n)
		req.rd && req.addr == {gpio_bank_pkg::KIND_DATA, 4'h4} && st.dir[2] == 16'h0000
			|=> rdata == $past(st.in_latch[2]);
	endproperty
	a_read_in: assert property (p_read_in) else $error("input pin read did not return the pin"); // R2

	property p_write_in;
		@(posedge sys_clk) disable iff (!rst_n)
		s_write_p2 ##0 st.dir[2] == 16'h0000
			|=> st.latch[2] == $past(req.wdata) && pins_oe[2] == 16'h0000;
	endproperty
	a_write_in: assert property (p_write_in) else $error("input pin write not kept in latch only"); // R2

	property p_read_out;
		@(posedge sys_clk) disable iff (!rst_n)
		req.rd && req.addr == {gpio_bank_pkg::KIND_DATA, 4'h4} && st.dir[2] == 16'hFFFF
			|=> rdata == $past(st.latch[2]);
	endproperty
	a_read_out: assert property (p_read_out) else $error("output pin read did not return latch"); // R5

	property p_toggle_out;
		@(posedge sys_clk) disable iff (!rst_n)
		s_toggle_p2 ##0 st.dir[2] == 16'hFFFF
			|=> st.latch[2] == $past(st.latch[2] ^ req.wdata);
	endproperty
	a_toggle_out: assert property (p_toggle_out) else $error("output modify not based on latch"); // R6

	property p_toggle_in;
		@(posedge sys_clk) disable iff (!rst_n)
		s_toggle_p2 ##0 st.dir[2] == 16'h0000
			|=> st.latch[2] == $past(st.in_latch[2] ^ req.wdata);
	endproperty
	a_toggle_in: assert property (p_toggle_in) else $error("input modify not based on pin"); // R3

	property p_od_high;
		@(posedge sys_clk) disable iff (!rst_n)
		(pins_oe[2] & st.od[2] & pins_o[2]) == 16'h0000;
	endproperty
	a_od_high: assert property (p_od_high) else $error("open drain pin drove a one"); // R7

	property p_od_ports;
		@(posedge sys_clk) disable iff (!rst_n)
		st.od[0] == 16'h0000 && st.od[1] == 16'h0000 && st.od[5] == 16'h0000;
	endproperty
	a_od_ports: assert property (p_od_ports) else $error("open drain set on a push-pull port"); // R7

	property p_thr_mask;
		@(posedge sys_clk) disable iff (!rst_n)
		((st.thr & ~gpio_bank_pkg::THR_MASK) | (st.xthr & ~gpio_bank_pkg::XTHR_MASK)) == 16'h0000;
	endproperty
	a_thr_mask: assert property (p_thr_mask) else $error("threshold bit outside the byte map"); // R8

	property p_thr_free;
		@(posedge sys_clk) disable iff (!rst_n)
		req.wr && (req.addr == gpio_bank_pkg::ADDR_THR || req.addr == gpio_bank_pkg::ADDR_XTHR)
			|=> $stable(st.dir) && $stable(st.od) && $stable(st.latch);
	endproperty
	a_thr_free: assert property (p_thr_free) else $error("threshold write disturbed pin control"); // R9

	property p_gap;
		@(posedge sys_clk) disable iff (!rst_n)
		{st.dir[3][14], st.latch[3][14], st.od[3][14], st.in_latch[3][14], pins_oe[3][14]} == 5'h00;
	endproperty
	a_gap: assert property (p_gap) else $error("missing line of third port came alive"); // R10

	property p_half_low;
		@(posedge sys_clk) disable iff (!rst_n)
		req.wr && req.addr == {gpio_bank_pkg::KIND_DATA, 4'h0}
			|=> st.latch[0] == {$past(st.latch[0][15:8]), $past(req.wdata[7:0])};
	endproperty
	a_half_low: assert property (p_half_low) else $error("low half write touched high byte"); // R12

	property p_half_high;
		@(posedge sys_clk) disable iff (!rst_n)
		req.wr && req.addr == {gpio_bank_pkg::KIND_DATA, 4'h1}
			|=> st.latch[0] == {$past(req.wdata[7:0]), $past(st.latch[0][7:0])};
	endproperty
	a_half_high: assert property (p_half_high) else $error("high half write touched low byte"); // R12

	property p_half_read;
		@(posedge sys_clk) disable iff (!rst_n)
		req.rd && req.addr == {gpio_bank_pkg::KIND_DATA, 4'h1} |=> rdata[15:8] == 8'h00;
	endproperty
	a_half_read: assert property (p_half_read) else $error("half read not placed in low byte"); // R12

	property p_auto;
		@(posedge sys_clk) disable iff (!rst_n)
		(AUTO_MASK[3] & alt_out_en[3] & gpio_bank_pkg::OUT_MASK[3] & ~pins_oe[3]
			& ~(st.od[3] & pins_o[3])) == 16'h0000;
	endproperty
	a_auto: assert property (p_auto) else $error("automatic pin not driven"); // R18

	property p_reset_state;
		@(posedge sys_clk)
		!rst_n |-> st.latch == '0 && st.dir == '0 && st.od == '0;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("control not cleared in reset"); // R16 R22

	property p_pwm_bypass;
		@(posedge sys_clk) disable iff (!rst_n)
		(pins_o[7] & alt_out_en[7] & alt_pwm_sel[7])
			== (alt_out_data[7] & alt_out_en[7] & alt_pwm_sel[7] & gpio_bank_pkg::OUT_MASK[7]);
	endproperty
	a_pwm_bypass: assert property (p_pwm_bypass) else $error("modulated output gated by latch"); // R15

	property p_rdata_idle;
		@(posedge sys_clk) disable iff (!rst_n)
		!req.rd |=> rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read"); // R2

	property p_latch_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		!req.wr |=> $stable(st.latch);
	endproperty
	a_latch_quiet: assert property (p_latch_quiet) else $error("latch moved without a write"); // R2
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the parallel I/O port bank
`timescale 1ns/1ps
module tb_top;
	logic                      sys_clk = 1'b0;
	logic                      resetn;
	gpio_bank_pkg::reg_req_t   req;
	logic [15:0]               rdata;
	gpio_bank_pkg::port_vec_t  pins_i;
	gpio_bank_pkg::port_vec_t  pins_o;
	gpio_bank_pkg::port_vec_t  pins_oe;
	gpio_bank_pkg::port_vec_t  alt_out_en;
	gpio_bank_pkg::port_vec_t  alt_out_data;
	gpio_bank_pkg::port_vec_t  alt_pwm_sel;
	gpio_bank_pkg::port_vec_t  alt_in;
	gpio_bank_pkg::ext_bus_t   ext_bus;
	gpio_bank_pkg::seg_addr_t  seg_addr;
	gpio_bank_pkg::thr_vec_t   cmos_sel;
	int                        error_cnt = 0;
	int                        checks_done = 0;

	always #4 sys_clk = ~sys_clk;

	gpio_bank dut_u (
		.sys_clk      (sys_clk),
		.resetn       (resetn),
		.req          (req),
		.rdata        (rdata),
		.pins_i       (pins_i),
		.pins_o       (pins_o),
		.pins_oe      (pins_oe),
		.alt_out_en   (alt_out_en),
		.alt_out_data (alt_out_data),
		.alt_pwm_sel  (alt_pwm_sel),
		.alt_in       (alt_in),
		.ext_bus      (ext_bus),
		.seg_addr     (seg_addr),
		.cmos_sel     (cmos_sel)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		req <= {a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		req <= {a, 16'h0000, 1'b0, 1'b1};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// Pin inputs pass two sync flops and a two-cycle state tick, so allow margin
	task automatic nap(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#20000;
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		// A clean falling edge so the reset flops never start unknown
		resetn = 1'b1;
		req = '0;
		pins_i = '0;
		alt_out_en = '0;
		alt_out_data = '0;
		alt_pwm_sel = '0;
		ext_bus = '0;
		seg_addr = '0;
		#1;
		resetn = 1'b0;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		nap(3);
		chk(pins_oe[2], 16'h0000);
		rd(8'h14, 16'h0000);
		rd(8'h24, 16'h0000);
		wr(8'h40, 16'hFFFF);
		rd(8'h40, 16'h01FF);
		chk({14'h0000, cmos_sel[2]}, 16'h0003);
		wr(8'h40, 16'h0010);
		chk({14'h0000, cmos_sel[4]}, 16'h0003);
		chk({14'h0000, cmos_sel[2]}, 16'h0000);
		wr(8'h41, 16'hFFFF);
		rd(8'h41, 16'h000F);
		chk({14'h0000, cmos_sel[0]}, 16'h0003);
		// CMOS thresholds stay on so later direction checks run under them
		wr(8'h40, 16'h01FF);
		@(posedge sys_clk);
		pins_i[2] <= 16'hA5A5;
		wr(8'h04, 16'h1234);
		nap(6);
		rd(8'h04, 16'hA5A5);
		chk(pins_oe[2], 16'h0000);
		wr(8'h34, 16'h00FF);
		wr(8'h14, 16'hFFFF);
		rd(8'h04, 16'hA55A);
		chk(pins_o[2], 16'hA55A);
		chk(pins_oe[2], 16'hFFFF);
		wr(8'h04, 16'hC33C);
		chk(pins_o[2], 16'hC33C);
		wr(8'h34, 16'h9999);
		rd(8'h04, 16'h5AA5);
		chk(pins_o[2], 16'h5AA5);
		chk(alt_in[2], 16'h5AA5);
		@(posedge sys_clk);
		pins_i[2] <= 16'h0F0F;
		nap(6);
		wr(8'h14, 16'h0000);
		rd(8'h04, 16'h0F0F);
		chk(alt_in[2], 16'h0F0F);
		wr(8'h14, 16'hFFFF);
		wr(8'h24, 16'h00FF);
		rd(8'h24, 16'h00FF);
		chk(pins_oe[2], 16'hFF5A);
		wr(8'h27, 16'hFFFF);
		rd(8'h27, 16'h0000);
		wr(8'h20, 16'hFFFF);
		rd(8'h20, 16'h0000);
		@(posedge sys_clk);
		alt_out_en[3] <= 16'h8000;
		nap(1);
		chk(pins_oe[3], 16'h8000);
		wr(8'h15, 16'hFFFF);
		rd(8'h15, 16'hBFFF);
		wr(8'h05, 16'hFFFF);
		rd(8'h05, 16'hBFFF);
		wr(8'h17, 16'hFFFF);
		rd(8'h17, 16'h0000);
		chk(pins_oe[5], 16'h0000);
		wr(8'h00, 16'h00AB);
		wr(8'h01, 16'h00CD);
		wr(8'h10, 16'h00FF);
		wr(8'h11, 16'h00FF);
		rd(8'h00, 16'h00AB);
		rd(8'h01, 16'h00CD);
		chk(pins_o[0], 16'hCDAB);
		chk(pins_oe[0], 16'hFFFF);
		@(posedge sys_clk);
		ext_bus <= {1'b1, 1'b0, 32'h2222_1111};
		nap(1);
		chk(pins_oe[0], 16'h0000);
		@(posedge sys_clk);
		ext_bus.drive <= 1'b1;
		nap(1);
		chk(pins_oe[1], 16'hFFFF);
		chk(pins_o[1], 16'h2222);
		chk(pins_o[0], 16'h1111);
		@(posedge sys_clk);
		alt_out_en[7] <= 16'h00FF;
		alt_out_data[7] <= 16'h00FF;
		seg_addr <= {1'b1, 8'h5A};
		nap(1);
		chk(pins_oe[7], 16'h0000);
		chk(pins_o[4] & 16'h00FF, 16'h005A);
		chk(pins_oe[4] & 16'h00FF, 16'h00FF);
		wr(8'h19, 16'h00FF);
		wr(8'h09, 16'h000F);
		chk(pins_o[7] & 16'h00FF, 16'h000F);
		chk(pins_oe[7], 16'h00FF);
		@(posedge sys_clk);
		alt_pwm_sel[7] <= 16'h00FF;
		nap(1);
		chk(pins_o[7] & 16'h00FF, 16'h00FF);
		wr(8'h4F, 16'hFFFF);
		rd(8'h4F, 16'h0000);
		tally_and_finish();
	end
endmodule
